// file: rtl/qdl_core.sv
// Serial frame receiver, buffers and load control of a quad converter
`timescale 1ns/100ps
`default_nettype none
module qdl_core (
  input  wire logic                                  sys_clk,
  input  wire logic                                  rst,
  input  wire logic                                  sclk_pin,
  input  wire logic                                  sync_n_pin,
  input  wire logic                                  din_pin,
  input  wire logic                                  enable_n_pin,
  input  wire logic                                  load_strobe_pin,
  input  wire logic                                  dev_addr_hi,
  input  wire logic                                  dev_addr_lo,
  output logic [qdl_pkg::CHAN_N-1:0][qdl_pkg::DATA_W-1:0] dac_code,
  output logic [qdl_pkg::CHAN_N-1:0][1:0]            dac_out_state,
  output logic                                       frame_overflow
);
  import qdl_pkg::*;

  typedef struct packed {
    logic [2:0]                         sclk_s;
    logic [2:0]                         sync_s;
    logic [1:0]                         din_s;
    logic [1:0]                         en_s;
    logic [2:0]                         ld_s;
    logic                               in_frame;
    logic [CNT_W-1:0]                   bit_cnt;
    logic [FRAME_BITS-2:0]              shift;
    logic [CHAN_N-1:0][DATA_W+2:0]      buf_word;
    logic [CHAN_N-1:0]                  buf_fresh;
    logic [CHAN_N-1:0][DATA_W-1:0]      code;
    logic [CHAN_N-1:0][1:0]             ostate;
    logic                               ovf;
  } qdl_state_t;

  qdl_state_t st_reg, st_next;

  // ==========================================================
  // Frame FIFO between receiver and buffer update
  logic                  f_in_valid;
  logic                  f_in_ready;
  logic [FIFO_W-1:0]     f_in_data;
  logic                  f_out_valid;
  logic [FIFO_W-1:0]     f_out_data;

  qdl_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) qdl_fifo_i (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (1'b1),
    .out_data  (f_out_data)
  );

  // ==========================================================
  // Edge detection on synchronised pins
  logic sclk_fall, sync_fall, sync_high, ld_rise, listen, last_edge;
  assign sclk_fall = st_reg.sclk_s[2] && !st_reg.sclk_s[1];
  assign sync_high = st_reg.sync_s[1];
  assign sync_fall = st_reg.sync_s[2] && !st_reg.sync_s[1];
  assign ld_rise   = !st_reg.ld_s[2] && st_reg.ld_s[1];
  assign listen    = !st_reg.en_s[1];
  assign last_edge = st_reg.in_frame && sclk_fall && !sync_high && listen && (st_reg.bit_cnt == LAST_BIT);
  assign f_in_data  = {st_reg.shift, st_reg.din_s[1]};
  assign f_in_valid = last_edge;

  function automatic logic [1:0] pd_state(input logic [2:0] m);
    if (!m[2])
      return OUT_ACTIVE;
    else if (m[1:0] == MODE_1K)
      return OUT_PD_1K;
    else if (m[1:0] == MODE_100K)
      return OUT_PD_100K;
    else
      return OUT_HIZ;
  endfunction

  // ==========================================================
  // Next-state logic
  logic [1:0] sel;
  logic       addr_ok;
  always_comb begin
    st_next = st_reg;
    st_next.sclk_s = {st_reg.sclk_s[1:0], sclk_pin};
    st_next.sync_s = {st_reg.sync_s[1:0], sync_n_pin};
    st_next.din_s  = {st_reg.din_s[0], din_pin};
    st_next.en_s   = {st_reg.en_s[0], enable_n_pin};
    st_next.ld_s   = {st_reg.ld_s[1:0], load_strobe_pin};
    sel     = {f_out_data[POS_SEL_HI], f_out_data[POS_SEL_LO]};
    addr_ok = (f_out_data[POS_ADDR_HI] == dev_addr_hi) && (f_out_data[POS_ADDR_LO] == dev_addr_lo);

    // frame opens at sync low, counts falling edges
    if (sync_high || !listen) begin
      st_next.in_frame = 1'b0;
      st_next.bit_cnt  = '0;
    end else if (sync_fall) begin
      st_next.in_frame = 1'b1;
      st_next.bit_cnt  = '0;
    end else if (st_reg.in_frame && sclk_fall) begin
      st_next.shift   = {st_reg.shift[FRAME_BITS-3:0], st_reg.din_s[1]};
      st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
      if (last_edge) begin
        st_next.in_frame = 1'b0;
        st_next.ovf      = st_reg.ovf | !f_in_ready;
      end
    end

    // strobe rise loads all fresh buffers
    if (ld_rise) begin
      for (int i = 0; i < CHAN_N; i++) begin
        if (st_reg.buf_fresh[i]) begin
          st_next.code[i]      = st_reg.buf_word[i][DATA_W-1:0];
          st_next.ostate[i]    = st_reg.buf_word[i][DATA_W+2] ?
                                 pd_state(st_reg.buf_word[i][DATA_W+2:DATA_W]) : OUT_ACTIVE;
          st_next.buf_fresh[i] = 1'b0;
        end
      end
    end

    if (f_out_valid && addr_ok) begin
      st_next.buf_word[sel] = {f_out_data[POS_PD], f_out_data[POS_MODE_HI], f_out_data[POS_MODE_LO],
                               f_out_data[DATA_W-1:0]};
      st_next.buf_fresh[sel] = 1'b1;
      for (int i = 0; i < CHAN_N; i++) begin
        // upper load bit loads every channel
        // load bits 01 load selected channel
        if (f_out_data[POS_LD_UP] || (f_out_data[POS_LD_LO] && (sel == i[1:0]))) begin
          st_next.buf_fresh[i] = 1'b0;
          if (sel == i[1:0]) begin
            st_next.code[i]   = f_out_data[DATA_W-1:0];
            st_next.ostate[i] = f_out_data[POS_PD] ?
                                pd_state({1'b1, f_out_data[POS_MODE_HI], f_out_data[POS_MODE_LO]}) : OUT_ACTIVE;
          end else begin
            st_next.code[i]   = st_reg.buf_word[i][DATA_W-1:0];
            st_next.ostate[i] = pd_state(st_reg.buf_word[i][DATA_W+2:DATA_W]);
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= '0;
      for (int i = 0; i < CHAN_N; i++) begin
        st_reg.code[i] <= RESET_CODE;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  assign dac_code       = st_reg.code;
  assign dac_out_state  = st_reg.ostate;
  assign frame_overflow = st_reg.ovf;

  // ==========================================================
  // Checks
  // no frame accepted while disabled
  a_disabled_no_frame: assert property (@(posedge sys_clk) disable iff (rst)
    !listen |-> !f_in_valid) else $error("frame taken while disabled");
  // frame emitted only on the 24th edge
  a_frame_at_24th: assert property (@(posedge sys_clk) disable iff (rst)
    f_in_valid |-> (st_reg.bit_cnt == LAST_BIT) && sclk_fall) else $error("frame not at 24th edge");
  a_single_frame: assert property (@(posedge sys_clk) disable iff (rst)
    f_in_valid |-> ##2 !st_reg.in_frame) else $error("second frame opened in same sync low");
  a_broadcast_load: assert property (@(posedge sys_clk) disable iff (rst)
    (f_out_valid && addr_ok && f_out_data[POS_LD_UP] && !ld_rise) |=>
      (st_reg.buf_fresh == '0)) else $error("broadcast left fresh buffer");
  a_stale_kept: assert property (@(posedge sys_clk) disable iff (rst)
    (ld_rise && !st_reg.buf_fresh[0] && !(f_out_valid && addr_ok)) |=>
      $stable(st_reg.code[0])) else $error("stale channel changed");
  a_strobe_load: assert property (@(posedge sys_clk) disable iff (rst)
    (ld_rise && !f_out_valid) |=> (st_reg.buf_fresh == '0)) else $error("strobe missed a buffer");
  a_foreign_addr: assert property (@(posedge sys_clk) disable iff (rst)
    (f_out_valid && !addr_ok && !ld_rise) |=> $stable(st_reg.code) && $stable(st_reg.buf_fresh))
    else $error("foreign frame accepted");
  // ordinary data load gives active output
  a_pd_exit: assert property (@(posedge sys_clk) disable iff (rst)
    (f_out_valid && addr_ok && f_out_data[POS_LD_LO] && !f_out_data[POS_PD] && !f_out_data[POS_LD_UP]
     && (sel == 2'h0) && !ld_rise) |=> (st_reg.ostate[0] == OUT_ACTIVE)) else $error("no power-down exit");
  a_write_only: assert property (@(posedge sys_clk) disable iff (rst)
    (f_out_valid && addr_ok && !f_out_data[POS_LD_UP] && !f_out_data[POS_LD_LO] && !ld_rise)
      |=> $stable(st_reg.code) ##0 st_reg.buf_fresh[$past(sel)]) else $error("write-only frame loaded");
  c_frame_taken:   cover property (@(posedge sys_clk) disable iff (rst) f_in_valid);
  c_strobe_load:   cover property (@(posedge sys_clk) disable iff (rst) ld_rise && (st_reg.buf_fresh != '0));
  c_broadcast:     cover property (@(posedge sys_clk) disable iff (rst) f_out_valid && f_out_data[POS_LD_UP]);
  c_powerdown:     cover property (@(posedge sys_clk) disable iff (rst) st_reg.ostate[0] == OUT_PD_1K);
endmodule : qdl_core
`default_nettype wire

// file: rtl/qdl_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module qdl_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } qdl_fifo_state_t;
  qdl_fifo_state_t st_reg, st_next;
  logic push, pop;

  assign in_ready  = (st_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data  = st_reg.mem[st_reg.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wptr] = in_data;
      st_next.wptr = st_reg.wptr + 1'b1;
    end
    if (pop) begin
      st_next.rptr = st_reg.rptr + 1'b1;
    end
    st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  a_fifo_no_over: assert property (@(posedge sys_clk) disable iff (rst)
    st_reg.count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : qdl_fifo
`default_nettype wire

// file: rtl/qdl_pkg.sv
// Shared constants for the quad converter load control block
package qdl_pkg;
  localparam int unsigned FRAME_BITS   = 24;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned CHAN_N       = 4;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam int unsigned FIFO_W       = 24;
  localparam int unsigned CNT_W        = 5;
  localparam logic [4:0]  LAST_BIT     = 5'h17;
  // Field positions inside a received frame
  localparam int unsigned POS_ADDR_HI  = 23;
  localparam int unsigned POS_ADDR_LO  = 22;
  localparam int unsigned POS_LD_UP    = 21;
  localparam int unsigned POS_LD_LO    = 20;
  localparam int unsigned POS_SEL_HI   = 18;
  localparam int unsigned POS_SEL_LO   = 17;
  localparam int unsigned POS_PD       = 16;
  localparam int unsigned POS_MODE_HI  = 15;
  localparam int unsigned POS_MODE_LO  = 14;
  // Output states, power-down modes and reset code of one channel
  localparam logic [1:0]  OUT_ACTIVE   = 2'h0;
  localparam logic [1:0]  OUT_HIZ      = 2'h1;
  localparam logic [1:0]  OUT_PD_1K    = 2'h2;
  localparam logic [1:0]  OUT_PD_100K  = 2'h3;
  localparam logic [1:0]  MODE_1K      = 2'h1;
  localparam logic [1:0]  MODE_100K    = 2'h2;
  localparam logic [15:0] RESET_CODE   = 16'h0000;
endpackage : qdl_pkg

// file: sim/qdl_host.sv
// Host serial port model driving frames into the load control block
`timescale 1ns/100ps
`default_nettype none
module qdl_host (
  input  wire logic sys_clk,
  output logic      sclk,
  output logic      sync_n,
  output logic      din
);
  initial begin
    sclk   = 1'b0;
    sync_n = 1'b1;
    din    = 1'b0;
  end

  task automatic wait_clk(input int unsigned n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_clk

  // ==========================================================
  // Frame transmit, clock idles low outside frames
  task automatic send(input logic [23:0] frame, input int unsigned nbits);
    wait_clk(1);
    sync_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      wait_clk(4);
      sclk <= 1'b1;
      din  <= frame[23-i];
      wait_clk(4);
      sclk <= 1'b0;
      if (i % 8 == 7) wait_clk(6);
    end
    wait_clk(4);
    sync_n <= 1'b1;
    // Released line, no pull: show the inverse
    din    <= ~din;
    wait_clk(6);
  endtask : send
endmodule : qdl_host
`default_nettype wire

// file: sim/quad_dac_load_control_bench.sv
// Self-checking bench for the quad converter load control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module quad_dac_load_control_bench;
  import qdl_pkg::*;
  localparam logic [1:0] ADDR = 2'h2;
  logic                          sys_clk, rst, sclk, sync_n, din, enable_n, strobe, a_hi, a_lo, ovf;
  logic [CHAN_N-1:0][DATA_W-1:0] code;
  logic [CHAN_N-1:0][1:0]        ostate;
  logic [1:0]                    pd_exp [4] = '{OUT_HIZ, OUT_PD_1K, OUT_PD_100K, OUT_HIZ};
  int                            bad_count, num_checks;

  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  qdl_host qdl_host_i (.sys_clk(sys_clk), .sclk(sclk), .sync_n(sync_n), .din(din));
  qdl_core qdl_core_i (.sys_clk(sys_clk), .rst(rst), .sclk_pin(sclk), .sync_n_pin(sync_n), .din_pin(din),
    .enable_n_pin(enable_n), .load_strobe_pin(strobe), .dev_addr_hi(a_hi), .dev_addr_lo(a_lo),
    .dac_code(code), .dac_out_state(ostate), .frame_overflow(ovf));

  // ==========================================================
  // Access tasks
  // frame field order
  function automatic logic [23:0] mk(input logic [1:0] ld, input logic [1:0] sel, input logic pd,
                                     input logic [15:0] data);
    return {ADDR, ld, 1'b0, sel, pd, data};
  endfunction : mk

  task automatic xfer(input logic [23:0] f, input int unsigned n);
    qdl_host_i.send(f, n);
    repeat (6) @(posedge sys_clk);
  endtask : xfer

  task automatic pulse_strobe();
    @(posedge sys_clk);
    strobe <= 1'b1;
    repeat (8) @(posedge sys_clk);
    strobe <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : pulse_strobe

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  // ==========================================================
  // Watchdog
  initial begin
    repeat (40000) @(posedge sys_clk);
    bad_count++;
    results();
  end

  // ==========================================================
  // Tests
  initial begin
    rst        = 1'b1;
    enable_n   = 1'b0;
    strobe     = 1'b0;
    {a_hi, a_lo} = ADDR;
    bad_count  = 0;
    num_checks = 0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    `CHK(code, '0)
    `CHK(ostate, '0)
    xfer(mk(2'h1, 2'h0, 1'b0, 16'h1234), 24);
    `CHK(code[0], 16'h1234)
    `CHK(code[1], 16'h0000)
    xfer(mk(2'h0, 2'h1, 1'b0, 16'h5555), 24);
    `CHK(code[1], 16'h0000)
    pulse_strobe();
    `CHK(code[1], 16'h5555)
    `CHK(code[0], 16'h1234)
    `CHK(code[3], 16'h0000)
    xfer(mk(2'h0, 2'h2, 1'b0, 16'h2222), 24);
    `CHK(code[2], 16'h0000)
    xfer(mk(2'h2, 2'h3, 1'b0, 16'h3333), 24);
    `CHK(code[2], 16'h2222)
    `CHK(code[3], 16'h3333)
    // Partial frame, one edge short
    xfer(mk(2'h1, 2'h0, 1'b0, 16'hbeef), 23);
    `CHK(code[0], 16'h1234)
    @(posedge sys_clk);
    enable_n <= 1'b1;
    xfer(mk(2'h1, 2'h0, 1'b0, 16'hdead), 24);
    `CHK(code[0], 16'h1234)
    @(posedge sys_clk);
    enable_n <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      if (a[1:0] != ADDR) begin
        xfer({a[1:0], 22'h10face}, 24);
        `CHK(code[0], 16'h1234)
      end
    end
    for (int m = 0; m < 4; m++) begin
      xfer(mk(2'h1, 2'h1, 1'b1, {m[1:0], 14'h0000}), 24);
      `CHK(ostate[1], pd_exp[m])
    end
    xfer(mk(2'h1, 2'h1, 1'b0, 16'h4321), 24);
    `CHK(ostate[1], OUT_ACTIVE)
    `CHK(code[1], 16'h4321)
    `CHK(ovf, 1'b0)
    results();
  end
endmodule : quad_dac_load_control_bench
`undef CHK
`default_nettype wire
